/* sram_host_ctrl.sv */
// Purpose: Host controller driving a 256K x 8 asynchronous static RAM.
// Assumes: 25 MHz clock; pins need a period of settling per phase.
// Notes:   One access at a time; all pin outputs come from flip-flops.
// Summary of operation
// - Write starts at last asserting edge
// - Write ends at first releasing edge
// - Host holds select long before write end
// - Host holds address valid before write end
// - Host drives data set-up before write end
// - Host keeps chip deselected during retention
// - Host drives every control to defined level
`timescale 1ns/1ps
module sram_host_ctrl
    import sram_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // User request port
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_retain,
    output logic o_ready,
    output logic o_rdata_valid,
    output logic [DATA_W-1:0] o_rdata,
    // Memory pins
    output logic [ADDR_W-1:0] o_addr_lines,
    output logic o_select_primary_n,
    output logic o_select_secondary,
    output logic o_output_enable_n,
    output logic o_write_strobe_n,
    output logic [DATA_W-1:0] o_byte_pins,
    output logic o_byte_pins_oe,
    input wire logic [DATA_W-1:0] i_byte_pins
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_WAIT, ST_RD_DONE, ST_WR_PULSE, ST_WR_END,
        ST_TURN, ST_RETAIN
    } phase_e;

    typedef struct packed {
        phase_e phase;
        logic [CNT_W-1:0] cnt;
        logic ready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [ADDR_W-1:0] addr;
        logic sel_pri_n;  // Primary select, active low
        logic sel_sec;    // Secondary select, active high
        logic oe_n;
        logic we_n;
        logic [DATA_W-1:0] wdata;
        logic drive;
    } ctrl_s;

    ctrl_s st_q, st_d;
    sram_sync_if sync_bus ();  // Synchronised returning byte

    // Returning byte passes four flops (three stages and the held value) before use
    sram_pin_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_pins(i_byte_pins),
        .sync(sync_bus.producer)
    );

    // Cycle count sized to the counter width
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = n[CNT_W-1:0];
    endfunction : cyc

    // Next-state logic for the access sequencer
    always_comb begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        case (st_q.phase)
            ST_IDLE: begin
                // Every control but the secondary select set to its inactive level while idle; secondary select keeps its last level
                st_d.sel_pri_n = 1'b1;
                st_d.oe_n = 1'b1;
                st_d.we_n = 1'b1;
                st_d.drive = 1'b0;
                st_d.ready = 1'b1;
                if (i_retain) begin
                    // Retention: deselect by both selects
                    st_d.sel_sec = 1'b0;
                    st_d.ready = 1'b0;
                    st_d.phase = ST_RETAIN;
                end else if (i_req) begin
                    st_d.ready = 1'b0;
                    st_d.sel_sec = 1'b1;
                    st_d.addr = i_addr;
                    st_d.sel_pri_n = 1'b0;
                    if (i_write) begin
                        // Address, select, data and strobe together
                        st_d.wdata = i_wdata;
                        st_d.drive = 1'b1;
                        st_d.we_n = 1'b0;
                        st_d.cnt = cyc(WRITE_HOLD_CYC - 1);
                        st_d.phase = ST_WR_PULSE;
                    end else begin
                        // Drivers stay off; device may drive
                        st_d.oe_n = 1'b0;
                        // Extra flops of the synchroniser added
                        st_d.cnt = cyc(ADDR_ACCESS_CYC + 3);
                        st_d.phase = ST_RD_WAIT;
                    end
                end
            end
            ST_RD_WAIT: begin
                if (st_q.cnt == '0) begin
                    st_d.phase = ST_RD_DONE;
                end else begin
                    st_d.cnt = st_q.cnt - cyc(1);
                end
            end
            ST_RD_DONE: begin
                st_d.rdata = sync_bus.data;
                st_d.rvalid = 1'b1;
                st_d.sel_pri_n = 1'b1;
                st_d.oe_n = 1'b1;
                st_d.cnt = cyc(DESELECT_FLOAT_CYC);
                st_d.phase = ST_TURN;
            end
            ST_WR_PULSE: begin
                // Select, address and data held long enough
                if (st_q.cnt == '0) begin
                    st_d.we_n = 1'b1;
                    st_d.phase = ST_WR_END;
                end else begin
                    st_d.cnt = st_q.cnt - cyc(1);
                end
            end
            ST_WR_END: begin
                // Data and address kept one cycle past end of write
                st_d.drive = 1'b0;
                st_d.sel_pri_n = 1'b1;
                st_d.cnt = cyc(0);
                st_d.phase = ST_TURN;
            end
            ST_TURN: begin
                if (st_q.cnt == '0) begin
                    st_d.ready = 1'b1;
                    st_d.phase = ST_IDLE;
                end else begin
                    st_d.cnt = st_q.cnt - cyc(1);
                end
            end
            ST_RETAIN: begin
                if (!i_retain) begin
                    st_d.ready = 1'b1;
                    st_d.phase = ST_IDLE;
                end
            end
            default: begin
                st_d.phase = ST_IDLE;
            end
        endcase
    end

    // State register; reset leaves the chip deselected
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '{phase: ST_IDLE, cnt: '0, ready: 1'b0,
                      rvalid: 1'b0, rdata: '0, addr: '0,
                      sel_pri_n: 1'b1, sel_sec: 1'b0, oe_n: 1'b1,
                      we_n: 1'b1, wdata: '0, drive: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_ready = st_q.ready;
    assign o_rdata_valid = st_q.rvalid;
    assign o_rdata = st_q.rdata;
    assign o_addr_lines = st_q.addr;
    assign o_select_primary_n = st_q.sel_pri_n;
    assign o_select_secondary = st_q.sel_sec;
    assign o_output_enable_n = st_q.oe_n;
    assign o_write_strobe_n = st_q.we_n;
    assign o_byte_pins = st_q.wdata;
    assign o_byte_pins_oe = st_q.drive;

    // Write strobe pulse lasts the full select-to-end time
    sequence s_wr_start;
        $fell(st_q.we_n);
    endsequence
    // Two cycles is 80 ns; must track WRITE_HOLD_CYC if the clock moves
    sequence s_wr_hold;
        (!st_q.we_n && !st_q.sel_pri_n && st_q.sel_sec && st_q.drive)[*2];
    endsequence
    a_wr_pulse_len: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        s_wr_start |-> s_wr_hold)
        else $error("write strobe pulse too short");

    // Address steady while strobe active
    a_wr_addr_stable: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !st_q.we_n && !$past(st_q.we_n) |-> $stable(st_q.addr))
        else $error("address moved during write");

    // Data driven whenever strobe is active; steady after its first cycle
    a_wr_data_driven: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !st_q.we_n |-> st_q.drive
            && ($past(st_q.we_n) || $stable(st_q.wdata)))
        else $error("write data not driven");

    // Strobe released before data or select drop
    a_wr_end_order: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        $rose(st_q.we_n) |-> st_q.drive && !st_q.sel_pri_n
            ##1 !st_q.drive && st_q.sel_pri_n)
        else $error("write end order broken");

    // Host never drives while a read is enabled
    a_no_contention: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !st_q.oe_n |-> !st_q.drive && st_q.we_n)
        else $error("host drives during read");

    // Read result follows output enable by the access wait
    // Seven-cycle wait (count 6 down to 0) and done phase give eight cycles
    a_rd_latency: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        $fell(st_q.oe_n) |-> ##8 st_q.rvalid)
        else $error("read data timing wrong");

    // Retention keeps the chip deselected
    a_retain_desel: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        st_q.phase == ST_RETAIN |-> !st_q.sel_sec && st_q.sel_pri_n
            && !st_q.drive)
        else $error("chip selected in retention");

    // Idle controls other than the secondary select at defined inactive levels
    a_idle_levels: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        st_q.phase == ST_IDLE |-> st_q.sel_pri_n && st_q.oe_n
            && st_q.we_n && !st_q.drive)
        else $error("idle control level wrong");
endmodule : sram_host_ctrl

/* sram_pkg.sv */
// Purpose: Constants for the host-side controller of a 256K x 8 static RAM.
// Assumes: 25 MHz system clock; slowest speed grade timing is used.
// Notes:   Cycle counts are derived from the printed times in ns.
package sram_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    // Read: address access time, slowest grade
    localparam int ADDR_ACCESS_NS = 100;
    localparam int ADDR_ACCESS_CYC =
        (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Write: select and address valid before end of write
    localparam int SELECT_TO_END_NS = 80;
    localparam int WRITE_HOLD_CYC =
        (SELECT_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Write data set-up before end of write
    localparam int DATA_SETUP_NS = 40;
    localparam int DATA_SETUP_CYC =
        (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Float time of the device after deselect
    localparam int DESELECT_FLOAT_NS = 30;
    localparam int DESELECT_FLOAT_CYC =
        (DESELECT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
endpackage : sram_pkg

/* sram_sync_if.sv */
// Purpose: Carries the synchronised read-data byte between modules.
// Assumes: One clock domain.
// Notes:   Producer is the pin synchroniser, consumer the controller.
`timescale 1ns/1ps
interface sram_sync_if;
    logic [7:0] data;  // Stable synchronised byte
    modport producer (output data);
    modport consumer (input data);
endinterface : sram_sync_if

/* sram_pin_sync.sv */
// Purpose: Three-stage synchroniser for the returning byte pins.
// Assumes: Pins are asynchronous to the system clock.
// Notes:   A value counts only once stage two and stage three agree.
`timescale 1ns/1ps
module sram_pin_sync (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Pin side
    input wire logic [7:0] i_pins,
    // Synchronised side
    sram_sync_if.producer sync
);
    typedef struct packed {
        logic [7:0] s1;    // Metastable stage, read only by s2
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] held;  // Last agreed value
    } sync_s;
    sync_s st_q, st_d;

    // Next state: shift, update held value when stages agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = i_pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.held = st_q.s3;
        end
    end

    // State register
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync.data = st_q.held;
endmodule : sram_pin_sync

/* sram_dev_model.sv */
// Purpose: Behavioural 256K x 8 static RAM facing the controller.
// Assumes: Slowest grade limits; no pull on the byte wire.
// Notes:   Released pins show the inverted old byte; faults in n_err.
`timescale 1ns/1ps
module sram_dev_model (
    // Pins from the host
    input wire logic [17:0] i_addr_lines,
    input wire logic i_select_primary_n,
    input wire logic i_select_secondary,
    input wire logic i_output_enable_n,
    input wire logic i_write_strobe_n,
    input wire logic [7:0] i_bus,
    input wire logic i_host_oe,
    // Pins back to the host
    output logic [7:0] o_pins
);
    logic [7:0] mem [0:262143];
    int access_ns = 100;  // Bench may make it prompt
    int n_err = 0;  // Host faults seen
    realtime t_sel, t_addr, t_data;
    logic drv = 1'b0;
    logic [7:0] last = 8'h00;
    wire sel = !i_select_primary_n && i_select_secondary;
    wire wr = sel && !i_write_strobe_n;
    wire rd = sel && !i_output_enable_n && i_write_strobe_n;
    always @(posedge sel) t_sel = $realtime;
    always @(i_addr_lines) t_addr = $realtime;
    always @(i_bus or i_host_oe) t_data = $realtime;
    // Store at end of write; set-ups are measured to that instant
    always @(negedge wr) begin
        if ($realtime - t_sel < 80 || $realtime - t_addr < 80)
            n_err++;
        if (!i_host_oe || $realtime - t_data < 40) n_err++;
        mem[i_addr_lines] = i_bus;
    end
    // Drive only after the access time, let go at once
    always @(posedge rd) begin
        #(access_ns);
        drv = rd;
    end
    always @(negedge rd) drv = 1'b0;
    always @(posedge drv) last = mem[i_addr_lines];
    // Old byte stays on the pins 15 ns after an address change
    always @(i_addr_lines) if (drv) last <= #15 mem[i_addr_lines];
    assign o_pins = drv ? last : ~last;
    // Both ends on the wire at once
    always @(posedge i_host_oe) if (drv) n_err++;
    always @(posedge drv) if (i_host_oe) n_err++;
endmodule : sram_dev_model

/* tb_top.sv */
// Purpose: Self-checking bench for the static RAM host controller.
// Assumes: Model stands in for the RAM; inputs move 2 ns after edges.
// Notes:   Every wait is bounded and ends the run when it runs out.
`timescale 1ns/1ps
module tb_top;
    import sram_pkg::*;
    logic i_clk_sys = 0, i_resetn = 0, req = 0, wr = 0, retain = 0;
    logic [ADDR_W-1:0] addr = '0, pin_addr;
    logic [DATA_W-1:0] wdata = '0, rdata, host_pins, dev_pins, bus, q;
    logic ready, rvalid, sel_n, sel2, oe_n, we_n, host_oe;
    int n_mismatch = 0, samples_checked = 0;
    always #20 i_clk_sys = ~i_clk_sys;  // 25 MHz
    // Resolved byte wire
    assign bus = host_oe ? host_pins : dev_pins;
    sram_host_ctrl dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_req(req), .i_write(wr), .i_addr(addr), .i_wdata(wdata),
        .i_retain(retain), .o_ready(ready), .o_rdata_valid(rvalid),
        .o_rdata(rdata), .o_addr_lines(pin_addr),
        .o_select_primary_n(sel_n), .o_select_secondary(sel2),
        .o_output_enable_n(oe_n), .o_write_strobe_n(we_n),
        .o_byte_pins(host_pins), .o_byte_pins_oe(host_oe),
        .i_byte_pins(bus));
    sram_dev_model dev (.i_addr_lines(pin_addr),
        .i_select_primary_n(sel_n), .i_select_secondary(sel2),
        .i_output_enable_n(oe_n), .i_write_strobe_n(we_n), .i_bus(bus),
        .i_host_oe(host_oe), .o_pins(dev_pins));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic tick;
        @(posedge i_clk_sys);
        #2;
    endtask : tick
    // A bound that runs out is a mismatch
    task automatic timeout;
        n_mismatch++;
        $display("CHECK FAILED wait expected done seen timeout");
        complete_run();
    endtask : timeout
    task automatic wait_ready;
        int n;
        n = 0;
        while (ready !== 1'b1) begin
            tick();
            n++;
            if (n > 40) timeout();
        end
    endtask : wait_ready
    // One whole access; a read returns its byte in q
    task automatic access(input logic w, input logic [17:0] a,
                          input logic [7:0] d);
        int n;
        wait_ready();
        req = 1; wr = w; addr = a; wdata = d;
        tick();
        req = 0;
        n = 0;
        if (w) wait_ready();
        else begin
            while (rvalid !== 1'b1) begin
                tick();
                n++;
                if (n > 20) timeout();
            end
            q = rdata;
            chk("read latency", n inside {[8:9]}, 1);
        end
    endtask : access
    task automatic t_reset;
        repeat (16) tick();
        chk("reset pins", {sel_n, sel2, oe_n, we_n, host_oe, ready,
            rvalid}, 7'b1011000);
        i_resetn = 1;
        tick();
        tick();
        chk("ready after reset", ready, 1);
    endtask : t_reset
    // Both ends of the array and one middle address, written back to back then read
    task automatic t_corners;
        logic [17:0] a [3] = '{18'h00000, 18'h3ffff, 18'h15a5a};
        logic [7:0] d [3] = '{8'ha5, 8'h5a, 8'h3c};
        foreach (a[i]) access(1, a[i], d[i]);
        foreach (a[i]) begin
            access(0, a[i], 8'h00);
            chk("read back", q, d[i]);
        end
    endtask : t_corners
    // Prompt and slow device answers
    task automatic t_speed;
        dev.access_ns = 10;
        access(0, 18'h3ffff, 8'h00);
        chk("prompt read", q, 8'h5a);
        dev.access_ns = 100;
        access(0, 18'h3ffff, 8'h00);
        chk("slow read", q, 8'h5a);
    endtask : t_speed
    // Request while busy is dropped
    task automatic t_refuse;
        access(1, 18'h00200, 8'h77);
        access(1, 18'h00100, 8'h11);
        wait_ready();
        req = 1; wr = 1; addr = 18'h00100; wdata = 8'h22;
        tick();
        req = 0;
        tick();
        chk("busy ready", ready, 0);
        req = 1; addr = 18'h00200; wdata = 8'hee;
        tick();
        req = 0;
        access(0, 18'h00200, 8'h00);
        chk("refused write", q, 8'h77);
        access(0, 18'h00100, 8'h00);
        chk("taken write", q, 8'h22);
    endtask : t_refuse
    // Retention holds the chip deselected and ignores requests
    task automatic t_retain;
        retain = 1; req = 1; wr = 1; addr = 18'h00200; wdata = 8'h99;
        repeat (4) tick();
        chk("retention pins", {sel_n, sel2, ready}, 3'b100);
        retain = 0;
        req = 0;
        access(0, 18'h00200, 8'h00);
        chk("kept byte", q, 8'h77);
    endtask : t_retain
    initial begin
        t_reset();
        t_corners();
        t_speed();
        t_refuse();
        t_retain();
        chk("host faults", dev.n_err, 0);
        complete_run();
    end
endmodule : tb_top
